// >>> rtl/tpc_pkg.sv
package tpc_pkg;

  // ------------------------------------------------------------------
  // Code-groups
  // ------------------------------------------------------------------
  localparam int SYM_BITS = 5;
  localparam logic [4:0] CG_IDLE = 5'h1F;
  localparam logic [4:0] CG_SSD1 = 5'h18;
  localparam logic [4:0] CG_SSD2 = 5'h11;
  localparam logic [4:0] CG_ESD1 = 5'h0D;
  localparam logic [4:0] CG_ESD2 = 5'h07;
  localparam logic [4:0] CG_TXERR = 5'h04;
  localparam logic [4:0] CG_LPI = 5'h00;

  // ------------------------------------------------------------------
  // Nibbles, entry layout, counts
  // ------------------------------------------------------------------
  localparam int NIB_W = 4;
  localparam int ENT_W = 6;
  localparam int ENT_EN = 5;
  localparam int ENT_ER = 4;
  localparam logic [3:0] NIB_PRE = 4'h5;
  localparam logic [3:0] NIB_BAD_SSD = 4'hE;
  localparam logic [3:0] NIB_LPI_REQ = 4'h1;
  localparam int SCR_W = 11;
  localparam int SCR_TAP = 8;
  localparam logic [4:0] LOCK_BITS = 5'h1E;
  localparam logic [3:0] IDLE_RUN = 4'hA;
  localparam int WIN_BYTES = 4000;
  localparam int BITS_PER_BYTE = 10;
  localparam int WIN_BITS = WIN_BYTES * BITS_PER_BYTE;
  localparam int FIFO_DEPTH = 8;
  localparam logic [1:0] MLT_POS = 2'h1;
  localparam logic [1:0] MLT_NEG = 2'h3;

  // ------------------------------------------------------------------
  // State types
  // ------------------------------------------------------------------
  typedef enum logic [3:0] {TX_IDLE = 4'h1, TX_SSD2 = 4'h2, TX_DATA = 4'h4,
    TX_ESD2 = 4'h8} tpc_tx_state_t;
  typedef enum logic [2:0] {RX_HUNT = 3'h1, RX_SSD2 = 3'h2, RX_FRAME = 3'h4} tpc_rx_state_t;

  // Nibble to data code-group
  function automatic logic [4:0] tpc_enc(input logic [3:0] n);
    logic [4:0] c;
    c = 5'h1E;
    case (n)
      4'h0: c = 5'h1E;
      4'h1: c = 5'h09;
      4'h2: c = 5'h14;
      4'h3: c = 5'h15;
      4'h4: c = 5'h0A;
      4'h5: c = 5'h0B;
      4'h6: c = 5'h0E;
      4'h7: c = 5'h0F;
      4'h8: c = 5'h12;
      4'h9: c = 5'h13;
      4'hA: c = 5'h16;
      4'hB: c = 5'h17;
      4'hC: c = 5'h1A;
      4'hD: c = 5'h1B;
      4'hE: c = 5'h1C;
      default: c = 5'h1D;
    endcase
    return c;
  endfunction

endpackage

// >>> rtl/tpc_stream_if.sv
`timescale 1ns/1ps
interface tpc_stream_if #(parameter int W = 6);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// >>> rtl/tpc_fifo.sv
`timescale 1ns/1ps
module tpc_fifo import tpc_pkg::*; #(
  parameter int WIDTH = ENT_W,
  parameter int DEPTH = FIFO_DEPTH
) (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Fill side
  tpc_stream_if.snk wr,
  // Drain side
  tpc_stream_if.src rd
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
  begin : g_bad_depth
    $error("FIFO depth must be a power of two, at least 2");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [CW-1:0] count_reg;
  logic [CW-1:0] count_next;
  logic ready_reg;
  wire push = wr.valid && ready_reg;
  wire pop = rd.valid && rd.ready;

  // Ready is kept as a flop so the source sees a clean level
  assign wr.ready = ready_reg;
  assign rd.valid = (count_reg != '0);
  assign rd.data = mem[rd_ptr_reg];
  assign count_next = count_reg + CW'(push) - CW'(pop);

  // Storage
  always_ff @(posedge clk)
  begin
    if (push)
      mem[wr_ptr_reg] <= wr.data;
  end

  // Pointers and fill level
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
      ready_reg <= 1'b0;
    end
    else
    begin
      wr_ptr_reg <= wr_ptr_reg + AW'(push);
      rd_ptr_reg <= rd_ptr_reg + AW'(pop);
      count_reg <= count_next;
      ready_reg <= (count_next != CW'(DEPTH));
    end
  end
endmodule

// >>> rtl/tpc_coder.sv
// Contract
// RQ1 - Data nibbles map to fixed data code-groups
// RQ2 - Idle is 11111, first start half 11000
// RQ3 - Rising enable sends start pair, second 10001
// RQ4 - Accept 10001 only after 11000, else error
// RQ5 - Falling enable appends 01101 then 00111
// RQ6 - 01101 then 00111 drops carrier; else error
// RQ7 - Lone 00111 raises receive error
// RQ8 - Transmit error sends code-group 00100
// RQ9 - Send 00000 before and during low power
// RQ10 - Received 00000 means low power, not data
// RQ11 - Unused code-groups during valid raise error
// RQ12 - Scrambler seed comes from management address
// RQ13 - Serialize each code-group one bit per cycle
// RQ14 - Scrambled bits become NRZI stream
// RQ15 - MLT-3: one moves level, zero holds
// RQ16 - Levels cycle zero, plus, zero, minus
// RQ17 - Receive descrambles and rebuilds code-groups
// RQ18 - Descrambler locks on idle, then holds key
// RQ19 - Idle must appear within rolling window
// RQ20 - Window expiry aborts and restarts locking
// RQ21 - Group boundary found from start pair
// RQ22 - Alignment kept until next start delimiter
// RQ23 - Start pair gives two 0101 nibbles, valid
// RQ24 - Bad start pair: error, 1110, no valid
`timescale 1ns/1ps
module tpc_coder import tpc_pkg::*; #(
  parameter int IDLE_WIN_BITS = WIN_BITS
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // MAC transmit nibbles, timed by the MAC link clock
  input wire logic mac_tx_clk,
  input wire logic mac_tx_en,
  input wire logic mac_tx_er,
  input wire logic [3:0] mac_txd,
  output logic mac_tx_ready,
  // Strap
  input wire logic [4:0] phy_mgmt_address,
  // Line transmit
  output logic line_nrzi,
  output logic line_mlt_pos,
  output logic line_mlt_neg,
  // Line receive levels
  input wire logic rx_mlt_pos,
  input wire logic rx_mlt_neg,
  // MAC receive
  output logic mac_rx_strobe,
  output logic [3:0] mac_rxd,
  output logic mac_rx_dv,
  output logic mac_rx_er,
  output logic mac_crs,
  output logic mac_rx_lpi,
  output logic descr_locked
);
  if (IDLE_WIN_BITS < 64 || IDLE_WIN_BITS > 1048575)
  begin : g_bad_win
    $error("Idle window out of range");
  end

  // ------------------------------------------------------------------
  // Input synchronisers
  // ------------------------------------------------------------------
  localparam int SW = 14;
  logic [SW-1:0] sa_reg;
  logic [SW-1:0] sb_reg;
  wire [SW-1:0] s_in = {mac_tx_clk, mac_tx_en, mac_tx_er, mac_txd, rx_mlt_pos, rx_mlt_neg,
    phy_mgmt_address};
  logic tclk_d_reg;
  logic seeded_reg;
  logic [1:0] sync_age_reg;
  wire sync_ok = (sync_age_reg == 2'h3);

  // Pins pass two flops; only the second stage is read.
  // Seed and link edges wait for sync_ok, so reset zeros are never taken as pin values
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      sa_reg <= '0;
      sb_reg <= '0;
      tclk_d_reg <= 1'b0;
      sync_age_reg <= 2'h0;
    end
    else
    begin
      sa_reg <= s_in;
      sb_reg <= sa_reg;
      tclk_d_reg <= sb_reg[13];
      sync_age_reg <= sync_age_reg + {1'b0, !sync_ok};
    end
  end

  // A link clock parked high across reset must not look like a fresh edge
  wire tclk_rise = sync_ok && sb_reg[13] && !tclk_d_reg;
  wire [ENT_W-1:0] tx_entry = sb_reg[12:7];
  wire [1:0] rx_lvl = sb_reg[6:5];
  wire [4:0] addr_s = sb_reg[4:0];

  // ------------------------------------------------------------------
  // Transmit FIFO
  // ------------------------------------------------------------------
  tpc_stream_if #(.W(ENT_W)) fin ();
  tpc_stream_if #(.W(ENT_W)) fout ();
  assign fin.valid = tclk_rise;
  assign fin.data = tx_entry;

  tpc_fifo #(.WIDTH(ENT_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(sys_clk),
    .arst_n(arst_n),
    .wr(fin),
    .rd(fout)
  );

  // ------------------------------------------------------------------
  // Transmit encoder and serializer
  // ------------------------------------------------------------------
  tpc_tx_state_t tx_st_reg;
  tpc_tx_state_t tx_st_next;
  logic [4:0] tx_sym;
  logic [4:0] shreg_reg;
  logic [2:0] left_reg;
  logic [SCR_W-1:0] lfsr_reg;
  logic [1:0] mlt_ph_reg;
  logic ready_out_reg;
  wire ent_en = fout.data[ENT_EN];
  wire ent_er = fout.data[ENT_ER];
  wire [3:0] ent_nib = fout.data[3:0];
  wire ent_lpi = !ent_en && ent_er && (ent_nib == NIB_LPI_REQ);
  wire tx_load = fout.valid && (left_reg <= 3'h1);
  wire tx_emit = (left_reg != 3'h0);
  wire scr_fb = lfsr_reg[SCR_W-1] ^ lfsr_reg[SCR_TAP];
  wire tx_sbit = tx_emit && (shreg_reg[4] ^ scr_fb);
  wire [1:0] mlt_ph_next = mlt_ph_reg + {1'b0, tx_sbit};
  assign fout.ready = (left_reg <= 3'h1);

  // One code-group per FIFO entry; the start pair replaces two preamble nibbles
  always_comb
  begin
    tx_st_next = tx_st_reg;
    tx_sym = CG_IDLE;
    case (tx_st_reg)
      TX_IDLE:
      begin
        if (ent_en)
        begin
          tx_sym = CG_SSD1; // RQ2 RQ3
          tx_st_next = TX_SSD2;
        end
        else if (ent_lpi)
          tx_sym = CG_LPI; // RQ9
        else
          tx_sym = CG_IDLE; // RQ2
      end
      TX_SSD2:
      begin
        tx_sym = CG_SSD2; // RQ3
        tx_st_next = ent_en ? TX_DATA : TX_ESD2;
        if (!ent_en)
          tx_sym = CG_ESD1;
      end
      TX_DATA:
      begin
        if (!ent_en)
        begin
          tx_sym = CG_ESD1; // RQ5
          tx_st_next = TX_ESD2;
        end
        else if (ent_er)
          tx_sym = CG_TXERR; // RQ8
        else
          tx_sym = tpc_enc(ent_nib); // RQ1
      end
      TX_ESD2:
      begin
        tx_sym = CG_ESD2; // RQ5
        tx_st_next = TX_IDLE;
      end
      default:
        tx_st_next = TX_IDLE;
    endcase
  end

  // Stalls hold the line; the scrambler only advances on emitted bits
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      tx_st_reg <= TX_IDLE;
      shreg_reg <= CG_IDLE;
      left_reg <= 3'h0;
      lfsr_reg <= '0;
      seeded_reg <= 1'b0;
      mlt_ph_reg <= 2'h0;
      line_nrzi <= 1'b0;
      line_mlt_pos <= 1'b0;
      line_mlt_neg <= 1'b0;
      ready_out_reg <= 1'b0;
    end
    else
    begin
      ready_out_reg <= fin.ready;
      seeded_reg <= sync_ok;
      if (!seeded_reg && sync_ok)
        lfsr_reg <= {1'b1, addr_s, addr_s}; // RQ12
      else if (tx_emit)
        lfsr_reg <= {lfsr_reg[SCR_W-2:0], scr_fb};
      if (tx_load)
      begin
        tx_st_reg <= tx_st_next;
        shreg_reg <= tx_sym;
        left_reg <= 3'(SYM_BITS); // RQ13
      end
      else if (tx_emit)
      begin
        shreg_reg <= {shreg_reg[3:0], 1'b0};
        left_reg <= left_reg - 3'h1;
      end
      line_nrzi <= line_nrzi ^ tx_sbit; // RQ14
      mlt_ph_reg <= mlt_ph_next; // RQ15 RQ16
      line_mlt_pos <= (mlt_ph_next == MLT_POS);
      line_mlt_neg <= (mlt_ph_next == MLT_NEG);
    end
  end
  assign mac_tx_ready = ready_out_reg;

  // ------------------------------------------------------------------
  // Receive: MLT-3 to bits, descrambler lock and idle window
  // ------------------------------------------------------------------
  logic [1:0] lvl_d_reg;
  logic [SCR_W-1:0] key_reg;
  logic [4:0] match_reg;
  logic [3:0] ones_reg;
  logic [19:0] win_reg;
  logic lock_reg;
  wire rbit = (rx_lvl != lvl_d_reg);
  wire key_fb = key_reg[SCR_W-1] ^ key_reg[SCR_TAP];
  wire plain = rbit ^ key_fb; // RQ17
  wire idle_seen = (ones_reg >= IDLE_RUN);
  wire win_exp = (win_reg == 20'(IDLE_WIN_BITS - 1));

  // While idle arrives the key bit equals the inverted line bit
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      lvl_d_reg <= 2'h0;
      key_reg <= '0;
      match_reg <= 5'h0;
      ones_reg <= 4'h0;
      win_reg <= 20'h0;
      lock_reg <= 1'b0;
    end
    else
    begin
      lvl_d_reg <= rx_lvl;
      if (!lock_reg)
      begin
        key_reg <= {key_reg[SCR_W-2:0], !rbit}; // RQ18
        match_reg <= (key_fb == !rbit) ? match_reg + 5'h1 : 5'h0;
        lock_reg <= (match_reg == LOCK_BITS);
        win_reg <= 20'h0;
        ones_reg <= 4'h0;
      end
      else
      begin
        key_reg <= {key_reg[SCR_W-2:0], key_fb}; // RQ18
        ones_reg <= plain ? (idle_seen ? ones_reg : ones_reg + 4'h1) : 4'h0;
        win_reg <= idle_seen ? 20'h0 : win_reg + 20'h1; // RQ19
        match_reg <= 5'h0;
        if (win_exp)
          lock_reg <= 1'b0; // RQ20
      end
    end
  end
  assign descr_locked = lock_reg;

  // ------------------------------------------------------------------
  // Receive: alignment and decoding
  // ------------------------------------------------------------------
  tpc_rx_state_t rx_st_reg;
  logic [4:0] grp_reg;
  logic [2:0] gcnt_reg;
  logic algn_reg;
  logic tpend_reg;
  logic pre2_reg;
  logic [4:0] dec;
  logic dec_ok;
  wire grp_done = algn_reg && (gcnt_reg == 3'h5);
  // Once aligned, only boundaries count: idle then 00000 would otherwise fake a start half
  wire ssd1_hit = lock_reg && (grp_reg == CG_SSD1) && (rx_st_reg != RX_SSD2)
    && (!algn_reg || grp_done);

  // Inverse table; dec_ok only for the data set
  always_comb
  begin
    dec_ok = 1'b0;
    dec = 5'h0;
    for (int i = 0; i < 16; i++)
    begin
      if (tpc_enc(4'(i)) == grp_reg)
      begin
        dec_ok = 1'b1;
        dec = {1'b0, 4'(i)};
      end
    end
  end

  // Group boundary is set by a first start half while unaligned and then kept until lock drops
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      grp_reg <= 5'h0;
      gcnt_reg <= 3'h0;
      algn_reg <= 1'b0;
    end
    else
    begin
      grp_reg <= lock_reg ? {grp_reg[3:0], plain} : 5'h0;
      if (!lock_reg)
        algn_reg <= 1'b0;
      else if (ssd1_hit)
      begin
        algn_reg <= 1'b1; // RQ21
        gcnt_reg <= 3'h1;
      end
      else
        gcnt_reg <= (gcnt_reg == 3'h5) ? 3'h1 : gcnt_reg + 3'h1; // RQ22
    end
  end

  // Frame sequencing and MAC side outputs
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rx_st_reg <= RX_HUNT;
      tpend_reg <= 1'b0;
      pre2_reg <= 1'b0;
      mac_rx_strobe <= 1'b0;
      mac_rxd <= 4'h0;
      mac_rx_dv <= 1'b0;
      mac_rx_er <= 1'b0;
      mac_crs <= 1'b0;
      mac_rx_lpi <= 1'b0;
    end
    else
    begin
      mac_rx_strobe <= pre2_reg;
      mac_rx_er <= 1'b0;
      mac_rx_lpi <= 1'b0;
      pre2_reg <= 1'b0;
      if (!lock_reg)
      begin
        rx_st_reg <= RX_HUNT; // RQ20
        mac_rx_dv <= 1'b0;
        mac_crs <= 1'b0;
        tpend_reg <= 1'b0;
      end
      else if (ssd1_hit)
      begin
        rx_st_reg <= RX_SSD2;
        mac_crs <= 1'b1;
        tpend_reg <= 1'b0;
      end
      else if (grp_done)
      begin
        case (rx_st_reg)
          RX_SSD2:
          begin
            mac_rx_strobe <= 1'b1;
            if (grp_reg == CG_SSD2)
            begin
              rx_st_reg <= RX_FRAME; // RQ4
              mac_rxd <= NIB_PRE; // RQ23
              mac_rx_dv <= 1'b1;
              pre2_reg <= 1'b1;
            end
            else
            begin
              rx_st_reg <= RX_HUNT;
              mac_rxd <= NIB_BAD_SSD; // RQ24
              mac_rx_er <= 1'b1; // RQ4
              mac_crs <= 1'b0;
            end
          end
          RX_FRAME:
          begin
            tpend_reg <= (grp_reg == CG_ESD1) && !tpend_reg;
            if (tpend_reg)
            begin
              rx_st_reg <= RX_HUNT;
              mac_rx_dv <= 1'b0;
              mac_crs <= 1'b0; // RQ6
              mac_rx_er <= (grp_reg != CG_ESD2); // RQ6
              mac_rx_strobe <= (grp_reg != CG_ESD2);
            end
            else if (dec_ok)
            begin
              mac_rxd <= dec[3:0];
              mac_rx_strobe <= 1'b1;
            end
            else if (grp_reg == CG_LPI)
              mac_rx_lpi <= 1'b1; // RQ10
            else if (grp_reg != CG_ESD1)
            begin
              mac_rx_er <= 1'b1; // RQ7 RQ11
              mac_rx_strobe <= 1'b1;
              if (grp_reg == CG_IDLE)
              begin
                rx_st_reg <= RX_HUNT;
                mac_rx_dv <= 1'b0;
                mac_crs <= 1'b0;
              end
            end
          end
          default:
          begin
            mac_rx_lpi <= (grp_reg == CG_LPI); // RQ10
            mac_rx_er <= (grp_reg == CG_ESD2); // RQ7
          end
        endcase
      end
    end
  end

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);

  sequence s_ssd_load;
    tx_load && tx_st_reg == TX_IDLE && ent_en;
  endsequence
  sequence s_rx_start;
    lock_reg && grp_done && rx_st_reg == RX_SSD2 && grp_reg == CG_SSD2 && !ssd1_hit;
  endsequence

  idle_send_a: assert property (tx_load && tx_st_reg == TX_IDLE && !ent_en && !ent_lpi // RQ2
    |=> shreg_reg == CG_IDLE) else $error("idle not sent");
  ssd_pair_a: assert property (s_ssd_load |=> shreg_reg == CG_SSD1 && tx_st_reg == TX_SSD2 // RQ3
    ##1 (tx_st_reg == TX_SSD2) [*4]) else $error("start pair broken");
  esd_pair_a: assert property (tx_load && tx_st_reg == TX_ESD2 // RQ5
    |=> shreg_reg == CG_ESD2 && tx_st_reg == TX_IDLE) else $error("end pair broken");
  txerr_sub_a: assert property (tx_load && tx_st_reg == TX_DATA && ent_en && ent_er // RQ8
    |=> shreg_reg == CG_TXERR) else $error("error symbol missing");
  lpi_send_a: assert property (tx_load && tx_st_reg == TX_IDLE && ent_lpi // RQ9
    |=> shreg_reg == CG_LPI) else $error("low power symbol missing");
  nrzi_toggle_a: assert property (line_nrzi != $past(line_nrzi) // RQ14
    |-> $past(tx_emit)) else $error("nrzi moved without a bit");
  mlt_order_a: assert property (mlt_ph_reg != $past(mlt_ph_reg) // RQ16
    |-> mlt_ph_reg == $past(mlt_ph_reg) + 2'h1 && !(line_mlt_pos && line_mlt_neg))
    else $error("mlt level order wrong");
  rx_preamble_a: assert property (s_rx_start |=> mac_rx_strobe && mac_rxd == NIB_PRE // RQ23
    && mac_rx_dv ##1 mac_rx_strobe && mac_rxd == NIB_PRE) else $error("preamble pair missing");
  bad_ssd_a: assert property (grp_done && rx_st_reg == RX_SSD2 && grp_reg != CG_SSD2 // RQ24
    && !ssd1_hit && lock_reg |=> mac_rx_er && mac_rxd == NIB_BAD_SSD && !mac_rx_dv)
    else $error("bad start not flagged");
  win_abort_a: assert property (lock_reg && win_exp |=> !lock_reg ##1 !mac_rx_dv) // RQ20
    else $error("window did not abort");
endmodule

// >>> sim/tpc_mac_model.sv
`timescale 1ns/1ps
// ------------------------------------------------------------------
// MAC side of the nibble link
// ------------------------------------------------------------------
module tpc_mac_model (
  // Clock
  input wire logic sys_clk,
  // Nibble link toward the coder
  output logic mac_tx_clk,
  output logic mac_tx_en,
  output logic mac_tx_er,
  output logic [3:0] mac_txd
);
  // Quiet link at time zero
  initial
  begin
    mac_tx_clk = 1'b0;
    mac_tx_en = 1'b0;
    mac_tx_er = 1'b0;
    mac_txd = 4'h0;
  end

  // One entry per 320 ns; data moves only while the link clock is low,
  // so it is steady across the synchronised rising edge.
  // The link clock stands high between entries rather than running free.
  task automatic send(input logic en, input logic er, input logic [3:0] d);
    @(posedge sys_clk);
    mac_tx_clk <= 1'b0;
    mac_tx_en <= en;
    mac_tx_er <= er;
    mac_txd <= d;
    repeat (4) @(posedge sys_clk);
    mac_tx_clk <= 1'b1;
    repeat (3) @(posedge sys_clk);
  endtask
endmodule

// >>> sim/test_tpc_coder.sv
`timescale 1ns/1ps
module test_tpc_coder import tpc_pkg::*; ();
  localparam int WIN = 300;
  localparam logic [4:0] DATA_CG [16] = '{5'h1E, 5'h09, 5'h14, 5'h15, 5'h0A, 5'h0B, 5'h0E,
    5'h0F, 5'h12, 5'h13, 5'h16, 5'h17, 5'h1A, 5'h1B, 5'h1C, 5'h1D};
  logic sys_clk, arst_n, rx_pos, rx_neg;
  logic [4:0] addr;
  logic mac_tx_clk, mac_tx_en, mac_tx_er, mac_tx_ready;
  logic [3:0] mac_txd, rxd;
  logic line_nrzi, line_mlt_pos, line_mlt_neg;
  logic strobe, mac_rx_dv, mac_rx_er, mac_crs, lpi, locked;
  int fail_count = 0;
  int total_checks = 0;
  int er_seen = 0;
  int lpi_seen = 0;
  logic [4:0] rx_q [$];
  logic [4:0] tx_q [$];
  logic [10:0] tx_scr;
  logic [10:0] rx_scr = 11'h5A3;
  logic [1:0] rx_ph = 2'h0;
  logic [11:0] rise_pipe;
  logic [7:0] tog;
  logic last_nrzi, last_clk;
  logic [1:0] mlt_ph;

  // ------------------------------------------------------------------
  // Design, partner and clock
  // ------------------------------------------------------------------
  tpc_coder #(.IDLE_WIN_BITS(WIN)) dut (.sys_clk(sys_clk), .arst_n(arst_n),
    .mac_tx_clk(mac_tx_clk), .mac_tx_en(mac_tx_en), .mac_tx_er(mac_tx_er), .mac_txd(mac_txd),
    .mac_tx_ready(mac_tx_ready), .phy_mgmt_address(addr), .line_nrzi(line_nrzi),
    .line_mlt_pos(line_mlt_pos), .line_mlt_neg(line_mlt_neg), .rx_mlt_pos(rx_pos),
    .rx_mlt_neg(rx_neg), .mac_rx_strobe(strobe), .mac_rxd(rxd), .mac_rx_dv(mac_rx_dv),
    .mac_rx_er(mac_rx_er), .mac_crs(mac_crs), .mac_rx_lpi(lpi), .descr_locked(locked));
  tpc_mac_model mac (.sys_clk(sys_clk), .mac_tx_clk(mac_tx_clk), .mac_tx_en(mac_tx_en),
    .mac_tx_er(mac_tx_er), .mac_txd(mac_txd));

  initial
  begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  task automatic check(input string what, input logic [4:0] seen, input logic [4:0] want);
    total_checks++;
    if (seen !== want)
    begin
      fail_count++;
      $display("BAD %s expected %h seen %h", what, want, seen);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Receive monitor plus line monitor; the line group window spans cycles
  // 4..11 after a link edge, tolerating a few cycles of pipeline choice
  always @(negedge sys_clk)
  begin
    logic [4:0] p;
    logic hit;
    if (strobe === 1'b1)
      rx_q.push_back({mac_rx_er, rxd});
    if (mac_rx_er === 1'b1)
      er_seen++;
    if (lpi === 1'b1)
      lpi_seen++;
    if (!arst_n)
    begin
      rise_pipe = 12'h000;
      tog = 8'h00;
      mlt_ph = 2'h0;
    end
    else
    begin
      tog = {tog[6:0], line_nrzi ^ last_nrzi};
      if (line_nrzi !== last_nrzi)
        mlt_ph = mlt_ph + 2'h1;
      check("mlt level", 5'({line_mlt_pos, line_mlt_neg}), 5'({mlt_ph == 2'h1, mlt_ph == 2'h3}));
      rise_pipe = {rise_pipe[10:0], mac_tx_clk & ~last_clk};
      if (rise_pipe[11] && tx_q.size() > 0)
      begin
        p = tx_q.pop_front();
        hit = 1'b0;
        for (int i = 0; i < 4; i++)
          hit |= (tog === ({p, 3'h0} >> i));
        check("line group", 5'(hit), 5'h01);
      end
    end
    last_nrzi = line_nrzi;
    last_clk = mac_tx_clk;
  end

  // ------------------------------------------------------------------
  // Drivers
  // ------------------------------------------------------------------
  task automatic do_reset(input logic [4:0] a);
    @(posedge sys_clk);
    arst_n <= 1'b0;
    addr <= a;
    repeat (5) @(posedge sys_clk);
    #1;
    check("reset out", {locked, mac_crs, mac_rx_dv, line_nrzi, mac_tx_ready}, 5'h00);
    @(posedge sys_clk);
    arst_n <= 1'b1;
    tx_scr = {1'b1, a, a};
    tx_q.delete();
    repeat (3) @(posedge sys_clk);
    #1;
  endtask

  // Expected line pattern is scrambled here from the seed, one key per bit
  task automatic tx_entry(input logic e, input logic r, input logic [3:0] d,
    input logic [4:0] c);
    logic k;
    logic [4:0] p;
    for (int i = 4; i >= 0; i--)
    begin
      k = tx_scr[10] ^ tx_scr[8];
      tx_scr = {tx_scr[9:0], k};
      p[i] = c[i] ^ k;
    end
    tx_q.push_back(p);
    mac.send(e, r, d);
  endtask

  // Far transmitter on the receive pair, one code bit per cycle
  task automatic send_cg(input logic [4:0] c);
    logic k;
    for (int i = 4; i >= 0; i--)
    begin
      @(posedge sys_clk);
      k = rx_scr[10] ^ rx_scr[8];
      rx_scr = {rx_scr[9:0], k};
      if (c[i] ^ k)
        rx_ph = rx_ph + 2'h1;
      rx_pos <= (rx_ph == 2'h1);
      rx_neg <= (rx_ph == 2'h3);
    end
    #1;
  endtask

  task automatic send_n(input logic [4:0] c, input int n);
    repeat (n) send_cg(c);
  endtask

  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  task automatic tx_run();
    check("ready", 5'(mac_tx_ready), 5'h01);
    repeat (3) tx_entry(1'b0, 1'b0, 4'h0, CG_IDLE);
    tx_entry(1'b1, 1'b0, 4'h5, CG_SSD1);
    tx_entry(1'b1, 1'b0, 4'h5, CG_SSD2);
    for (int i = 0; i < 16; i++)
      tx_entry(1'b1, i == 7, 4'(i), (i == 7) ? CG_TXERR : DATA_CG[i]);
    tx_entry(1'b0, 1'b0, 4'h0, CG_ESD1);
    tx_entry(1'b0, 1'b0, 4'h0, CG_ESD2);
    tx_entry(1'b0, 1'b0, 4'h0, CG_IDLE);
    repeat (2) tx_entry(1'b0, 1'b1, 4'h1, CG_LPI);
    tx_entry(1'b0, 1'b0, 4'h0, CG_IDLE);
    repeat (16) @(posedge sys_clk);
    #1;
    check("tx groups left", 5'(tx_q.size()), 5'h00);
  endtask

  task automatic rx_lock();
    send_n(CG_IDLE, 40);
    check("locked", 5'(locked), 5'h01);
  endtask

  task automatic rx_frame();
    rx_q.delete();
    send_cg(CG_SSD1);
    send_cg(CG_SSD2);
    for (int i = 0; i < 16; i++)
      send_cg(DATA_CG[i]);
    check("dv in frame", 5'(mac_rx_dv), 5'h01);
    send_cg(CG_ESD1);
    send_cg(CG_ESD2);
    send_n(CG_IDLE, 4);
    check("carrier after end", {3'h0, mac_crs, mac_rx_dv}, 5'h00);
    check("rx count", 5'(rx_q.size()), 5'h12);
    for (int i = 0; i < 18; i++)
      check("rx nibble", rx_q[i], (i < 2) ? {1'b0, NIB_PRE} : {1'b0, 4'(i - 2)});
  endtask

  task automatic rx_lpi();
    int l0 = lpi_seen;
    int n0 = rx_q.size();
    send_cg(CG_LPI);
    send_n(CG_IDLE, 2);
    check("lpi notice", 5'(lpi_seen - l0), 5'h01);
    check("lpi no data", 5'(rx_q.size() - n0), 5'h00);
  endtask

  task automatic rx_bad_ssd();
    rx_q.delete();
    send_cg(CG_SSD1);
    send_cg(DATA_CG[5]);
    send_n(CG_IDLE, 4);
    check("bad start", rx_q[0], {1'b1, NIB_BAD_SSD});
    check("bad start flags", {mac_rx_dv, mac_crs, 3'h0}, 5'h00);
    check("bad start count", 5'(rx_q.size()), 5'h01);
  endtask

  // Invalid groups, an end half with no partner, and a lone second end half
  task automatic rx_bad_frame();
    logic [4:0] bad [5] = '{5'h06, 5'h19, 5'h01, CG_ESD1, CG_ESD2};
    int e0;
    for (int j = 0; j < 5; j++)
    begin
      e0 = er_seen;
      send_cg(CG_SSD1);
      send_cg(CG_SSD2);
      send_cg(DATA_CG[3]);
      send_cg(bad[j]);
      send_n(CG_IDLE, 4);
      check("frame error", 5'(er_seen > e0), 5'h01);
      check("frame error end", {mac_rx_dv, mac_crs, 3'h0}, 5'h00);
    end
  endtask

  // Long frame without idle: lock holds inside the window, drops past it
  task automatic rx_window();
    send_cg(CG_SSD1);
    send_cg(CG_SSD2);
    send_n(DATA_CG[0], 50);
    check("lock kept", {mac_crs, locked, 3'h0}, 5'h18);
    send_n(DATA_CG[0], 14);
    check("lock lost", {mac_crs, locked, mac_rx_dv, 2'h0}, 5'h00);
    rx_lock();
  endtask

  // Hang guard
  initial
  begin
    repeat (100000) @(posedge sys_clk);
    fail_count++;
    complete_run();
  end

  initial
  begin
    arst_n = 1'b0;
    addr = 5'h05;
    rx_pos = 1'b0;
    rx_neg = 1'b0;
    do_reset(5'h05);
    tx_run();
    rx_lock();
    rx_frame();
    rx_lpi();
    rx_bad_ssd();
    rx_bad_frame();
    rx_window();
    do_reset(5'h1A);
    tx_run();
    complete_run();
  end
endmodule
